// File: hw/uart_link_pkg.sv
// Shared constants for the serial port and its host controller.
package uart_link_pkg;
  // ==========================================================================
  // Clock, buffers and framing
  // ==========================================================================
  localparam int CLOCK_HZ = 125_000_000;
  localparam int BAUD_W = 20;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int DATA_BITS = 8;
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_EVEN = 2'h1;
  localparam logic [1:0] PARITY_ODD = 2'h2;
  localparam logic [3:0] FRAME_BASE_BITS = 4'ha;
  localparam logic [3:0] PARITY_INDEX = 4'h8;
  localparam logic [3:0] STOP_INDEX_NO_PARITY = 4'h8;
  // ==========================================================================
  // Host controller register map (byte addresses) and fields
  // ==========================================================================
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_TXDATA = 5'h08;
  localparam logic [4:0] ADDR_RXDATA = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;
  localparam int CTRL_BAUD_LSB = 0;
  localparam int CTRL_PARITY_LSB = 3;
  localparam int CTRL_STOP_BIT = 5;
  localparam int CTRL_CTS_EN_BIT = 6;
  localparam int CTRL_RTS_EN_BIT = 7;
  localparam int CTRL_RTS_HOLD_BIT = 8;
  localparam logic [8:0] CTRL_RESET = 9'h007;
  localparam int IRQ_W = 4;
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_OVERRUN = 2;
  localparam int IRQ_FRAME_ERR = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // Clock cycles per bit for each baud rate setting.
  function automatic logic [BAUD_W-1:0] baud_div(input int hz, input logic [2:0] sel);
    int rate;
    case (sel)
      3'h0: rate = 1200;
      3'h1: rate = 2400;
      3'h2: rate = 4800;
      3'h3: rate = 9600;
      3'h4: rate = 19200;
      3'h5: rate = 38400;
      3'h6: rate = 57600;
      default: rate = 115200;
    endcase
    return BAUD_W'(hz / rate);
  endfunction

  // Parity bit for a data byte under a parity mode.
  function automatic logic parity_of(input logic [7:0] data, input logic [1:0] mode);
    return (mode == PARITY_ODD) ? ~(^data) : ^data;
  endfunction
endpackage

// File: hw/uart_link_if.sv
// Serial link between the radio module port and the host controller.
`timescale 1ns/1ps
interface uart_link_if;
  logic host_to_dev;
  logic dev_to_host;
  logic cts_n;
  logic rts_n;
  modport device (input host_to_dev, input rts_n, output dev_to_host, output cts_n);
  modport host (output host_to_dev, output rts_n, input dev_to_host, input cts_n);
endinterface

// File: hw/serial_port_device.sv
// Radio module host serial port with receive and transmit buffers and flow control.
// What this block does
// - Buffer each received byte with good parity and stop bit, while room remains, until processing consumes it.
// - Drop incoming bytes when receive buffer is full.
// - Deassert CTS when occupancy exceeds threshold.
// - Reassert CTS only when occupancy below threshold.
// - Host stops sending while CTS deasserted.
// - Hold transmit data while RTS is deasserted.
// - Up to five characters may follow RTS.
// - Host avoids holding RTS deasserted long.
// - Radio payloads leave the serial output in order.
// - Discard whole packet lacking transmit buffer room.
// - Host idles its transmit line high.
// - Frame: start low, 8 bits LSB first, stop.
// - Host matches baud, parity and stop settings.
// - Baud, parity, stop bits from three settings.
// - Sleep parks serial output low, CTS kept.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module serial_port_device
  import uart_link_pkg::*;
#(
  parameter int CLOCK_FREQ_HZ = CLOCK_HZ
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Serial link.
  uart_link_if.device link,
  // Configuration settings.
  input wire logic [2:0] baud_rate_setting,
  input wire logic [1:0] parity_setting,
  input wire logic stop_bits_setting,
  input wire logic cts_pin_config,
  input wire logic rts_pin_config,
  input wire logic [CNT_W-1:0] flow_threshold_bytes,
  input wire logic [1:0] sleep_mode_select,
  input wire logic sleep_request,
  // Internal processing side of the receive buffer.
  output logic [7:0] proc_data,
  output logic proc_valid,
  input wire logic proc_ready,
  // Radio payload side of the transmit buffer.
  input wire logic radio_start,
  input wire logic [CNT_W-1:0] radio_len,
  input wire logic [7:0] radio_data,
  input wire logic radio_valid,
  output logic radio_drop,
  // Status.
  output logic [CNT_W-1:0] rx_level,
  output logic [CNT_W-1:0] tx_level
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

  // ==========================================================================
  // Settings and input synchronisers
  // ==========================================================================
  logic [BAUD_W-1:0] bit_div;
  logic parity_on;
  logic sleeping;
  logic din_meta_reg, din_sync_reg, rts_meta_reg, rts_sync_reg;

  assign bit_div = baud_div(CLOCK_FREQ_HZ, baud_rate_setting);
  assign parity_on = (parity_setting == PARITY_EVEN) || (parity_setting == PARITY_ODD);
  assign sleeping = sleep_request && (sleep_mode_select != 2'h0);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      din_meta_reg <= 1'b1;
      din_sync_reg <= 1'b1;
      rts_meta_reg <= 1'b1;
      rts_sync_reg <= 1'b1;
    end else begin
      din_meta_reg <= link.host_to_dev;
      din_sync_reg <= din_meta_reg;
      rts_meta_reg <= link.rts_n;
      rts_sync_reg <= rts_meta_reg;
    end
  end

  // ==========================================================================
  // Serial receiver
  // ==========================================================================
  rx_state_t rx_state_reg;
  logic [BAUD_W-1:0] rx_cnt_reg;
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_byte_reg;
  logic rx_bad_reg, rx_done_reg;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_idx_reg <= 4'h0;
      rx_byte_reg <= 8'h00;
      rx_bad_reg <= 1'b0;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          if (!din_sync_reg) begin
            rx_state_reg <= RX_START;
            rx_cnt_reg <= bit_div >> 1;
          end
        end
        RX_START: begin
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else if (!din_sync_reg) begin
            rx_state_reg <= RX_BITS;
            rx_cnt_reg <= bit_div - 1'b1;
            rx_idx_reg <= 4'h0;
            rx_bad_reg <= 1'b0;
          end else begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: begin
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else begin
            rx_cnt_reg <= bit_div - 1'b1;
            rx_idx_reg <= rx_idx_reg + 1'b1;
            if (rx_idx_reg < PARITY_INDEX) begin
              rx_byte_reg <= {din_sync_reg, rx_byte_reg[7:1]};
            end else if (rx_idx_reg == PARITY_INDEX && parity_on) begin
              rx_bad_reg <= din_sync_reg != parity_of(rx_byte_reg, parity_setting);
            end else begin
              rx_done_reg <= din_sync_reg && !rx_bad_reg;
              rx_state_reg <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Receive buffer and clear-to-send
  // ==========================================================================
  logic [7:0] rx_mem [DEPTH];
  logic [PTR_W-1:0] rx_wr_reg, rx_rd_reg;
  logic [CNT_W-1:0] rx_count_reg;
  logic rx_push, rx_pop, cts_n_reg;

  assign rx_push = rx_done_reg && (rx_count_reg < CNT_W'(DEPTH));
  assign rx_pop = proc_valid && proc_ready;
  assign proc_valid = rx_count_reg != '0;
  assign proc_data = rx_mem[rx_rd_reg];
  assign rx_level = rx_count_reg;

  always_ff @(posedge clock) begin
    if (rx_push) begin
      rx_mem[rx_wr_reg] <= rx_byte_reg;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rx_count_reg <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_reg <= rx_wr_reg + 1'b1;
      end
      if (rx_pop) begin
        rx_rd_reg <= rx_rd_reg + 1'b1;
      end
      rx_count_reg <= rx_count_reg + CNT_W'(rx_push) - CNT_W'(rx_pop);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cts_n_reg <= 1'b0;
    end else if (!cts_pin_config) begin
      cts_n_reg <= 1'b0;
    end else if (rx_count_reg > flow_threshold_bytes) begin
      cts_n_reg <= 1'b1;
    end else if (rx_count_reg < flow_threshold_bytes) begin
      cts_n_reg <= 1'b0;
    end
  end

  assign link.cts_n = cts_n_reg;

  // ==========================================================================
  // Transmit buffer with whole-packet admission
  // ==========================================================================
  logic [7:0] tx_mem [DEPTH];
  logic [PTR_W-1:0] tx_wr_reg, tx_rd_reg;
  logic [CNT_W-1:0] tx_count_reg;
  logic pkt_open_reg, radio_drop_reg, tx_push, tx_pop, tx_fits;

  assign tx_fits = radio_len <= (CNT_W'(DEPTH) - tx_count_reg);
  assign tx_push = radio_valid && pkt_open_reg && (tx_count_reg < CNT_W'(DEPTH));
  assign radio_drop = radio_drop_reg;
  assign tx_level = tx_count_reg;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pkt_open_reg <= 1'b0;
      radio_drop_reg <= 1'b0;
    end else begin
      radio_drop_reg <= radio_start && !tx_fits;
      if (radio_start) begin
        pkt_open_reg <= tx_fits;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (tx_push) begin
      tx_mem[tx_wr_reg] <= radio_data;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_count_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_wr_reg <= tx_wr_reg + 1'b1;
      end
      if (tx_pop) begin
        tx_rd_reg <= tx_rd_reg + 1'b1;
      end
      tx_count_reg <= tx_count_reg + CNT_W'(tx_push) - CNT_W'(tx_pop);
    end
  end

  // ==========================================================================
  // Serial transmitter
  // ==========================================================================
  logic [11:0] tx_frame_reg;
  logic [3:0] tx_bits_reg;
  logic [BAUD_W-1:0] tx_cnt_reg;
  logic tx_busy_reg, tx_hold;
  logic [7:0] tx_head;

  assign tx_head = tx_mem[tx_rd_reg];
  assign tx_hold = (rts_pin_config && rts_sync_reg) || sleeping;
  assign tx_pop = !tx_busy_reg && (tx_count_reg != '0) && !tx_hold;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_frame_reg <= 12'hfff;
      tx_bits_reg <= 4'h0;
      tx_cnt_reg <= '0;
      tx_busy_reg <= 1'b0;
    end else if (!tx_busy_reg) begin
      if (tx_pop) begin
        tx_frame_reg <= parity_on ?
            {2'b11, parity_of(tx_head, parity_setting), tx_head, 1'b0} :
            {3'b111, tx_head, 1'b0};
        tx_bits_reg <= FRAME_BASE_BITS + {3'h0, parity_on} + {3'h0, stop_bits_setting};
        tx_cnt_reg <= bit_div - 1'b1;
        tx_busy_reg <= 1'b1;
      end
    end else if (tx_cnt_reg != '0) begin
      tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end else begin
      tx_cnt_reg <= bit_div - 1'b1;
      tx_frame_reg <= {1'b1, tx_frame_reg[11:1]};
      tx_bits_reg <= tx_bits_reg - 1'b1;
      if (tx_bits_reg == 4'h1) begin
        tx_busy_reg <= 1'b0;
      end
    end
  end

  assign link.dev_to_host = sleeping ? 1'b0 : tx_frame_reg[0];
endmodule // serial_port_device

// File: hw/serial_host_ctrl.sv
// Host-side serial controller with Avalon-MM registers, CTS/RTS handling and interrupt.
`timescale 1ns/1ps
module serial_host_ctrl
  import uart_link_pkg::*;
#(
  parameter int CLOCK_FREQ_HZ = CLOCK_HZ
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Serial link.
  uart_link_if.host link,
  // Avalon-MM slave.
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Interrupt.
  output logic irq
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [8:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_status_reg, irq_mask_reg, irq_set;
  logic [31:0] readdata_reg;
  logic rd_ack_reg, hold_valid_reg, rx_valid_reg, tx_busy_reg, rx_done_reg, rx_bad_reg;
  logic [7:0] hold_reg, rx_data_reg, rx_byte_reg;
  logic [BAUD_W-1:0] bit_div;
  logic [1:0] parity_mode;
  logic parity_on, tx_wr, rx_rd, cts_meta_reg, cts_sync_reg, din_meta_reg, din_sync_reg;

  assign bit_div = baud_div(CLOCK_FREQ_HZ, ctrl_reg[CTRL_BAUD_LSB +: 3]);
  assign parity_mode = ctrl_reg[CTRL_PARITY_LSB +: 2];
  assign parity_on = (parity_mode == PARITY_EVEN) || (parity_mode == PARITY_ODD);
  assign tx_wr = write && (address == ADDR_TXDATA) && !hold_valid_reg;
  assign rx_rd = read && rd_ack_reg && (address == ADDR_RXDATA);
  assign waitrequest = (read && !rd_ack_reg) || (write && address == ADDR_TXDATA && hold_valid_reg);
  assign readdata = readdata_reg;
  assign irq = |(irq_status_reg & irq_mask_reg);
  assign link.rts_n = ctrl_reg[CTRL_RTS_EN_BIT] && ctrl_reg[CTRL_RTS_HOLD_BIT];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_ack_reg <= 1'b0;
      readdata_reg <= 32'h00000000;
    end else begin
      rd_ack_reg <= read && !rd_ack_reg;
      if (read && !rd_ack_reg) begin
        if (address == ADDR_CTRL) begin
          readdata_reg <= {23'h000000, ctrl_reg};
        end else if (address == ADDR_STATUS) begin
          readdata_reg <= {28'h0000000, cts_sync_reg, rx_valid_reg, tx_busy_reg, hold_valid_reg};
        end else if (address == ADDR_RXDATA) begin
          readdata_reg <= {24'h000000, rx_data_reg};
        end else if (address == ADDR_IRQ_STATUS) begin
          readdata_reg <= {28'h0000000, irq_status_reg};
        end else if (address == ADDR_IRQ_MASK) begin
          readdata_reg <= {28'h0000000, irq_mask_reg};
        end else begin
          readdata_reg <= UNMAPPED_READ;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
      irq_status_reg <= '0;
    end else begin
      if (write && address == ADDR_CTRL) begin
        ctrl_reg <= writedata[8:0];
      end
      if (write && address == ADDR_IRQ_MASK) begin
        irq_mask_reg <= writedata[IRQ_W-1:0];
      end
      if (write && address == ADDR_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg & ~writedata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_status_reg <= irq_status_reg | irq_set;
      end
    end
  end

  // ==========================================================================
  // Synchronisers
  // ==========================================================================
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cts_meta_reg <= 1'b0;
      cts_sync_reg <= 1'b0;
      din_meta_reg <= 1'b1;
      din_sync_reg <= 1'b1;
    end else begin
      cts_meta_reg <= link.cts_n;
      cts_sync_reg <= cts_meta_reg;
      din_meta_reg <= link.dev_to_host;
      din_sync_reg <= din_meta_reg;
    end
  end

  // ==========================================================================
  // Transmitter
  // ==========================================================================
  logic [11:0] tx_frame_reg;
  logic [3:0] tx_bits_reg;
  logic [BAUD_W-1:0] tx_cnt_reg;
  logic tx_start, tx_end;

  assign tx_start = !tx_busy_reg && hold_valid_reg && !(ctrl_reg[CTRL_CTS_EN_BIT] && cts_sync_reg);
  assign tx_end = tx_busy_reg && tx_cnt_reg == '0 && tx_bits_reg == 4'h1;
  assign link.host_to_dev = tx_frame_reg[0];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hold_valid_reg <= 1'b0;
      hold_reg <= 8'h00;
    end else if (tx_wr) begin
      hold_valid_reg <= 1'b1;
      hold_reg <= writedata[7:0];
    end else if (tx_start) begin
      hold_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_frame_reg <= 12'hfff;
      tx_bits_reg <= 4'h0;
      tx_cnt_reg <= '0;
      tx_busy_reg <= 1'b0;
    end else if (tx_start) begin
      tx_frame_reg <= parity_on ? {2'b11, parity_of(hold_reg, parity_mode), hold_reg, 1'b0} :
          {3'b111, hold_reg, 1'b0};
      tx_bits_reg <= FRAME_BASE_BITS + {3'h0, parity_on} + {3'h0, ctrl_reg[CTRL_STOP_BIT]};
      tx_cnt_reg <= bit_div - 1'b1;
      tx_busy_reg <= 1'b1;
    end else if (tx_busy_reg && tx_cnt_reg != '0) begin
      tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end else if (tx_busy_reg) begin
      tx_cnt_reg <= bit_div - 1'b1;
      tx_frame_reg <= {1'b1, tx_frame_reg[11:1]};
      tx_bits_reg <= tx_bits_reg - 1'b1;
      tx_busy_reg <= !tx_end;
    end
  end

  // ==========================================================================
  // Receiver
  // ==========================================================================
  rx_state_t rx_state_reg;
  logic [BAUD_W-1:0] rx_cnt_reg;
  logic [3:0] rx_idx_reg;
  logic rx_frame_err_reg;

  assign irq_set = {rx_frame_err_reg, rx_done_reg && rx_valid_reg && !rx_rd, tx_end, rx_done_reg};

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_idx_reg <= 4'h0;
      rx_byte_reg <= 8'h00;
      rx_bad_reg <= 1'b0;
      rx_done_reg <= 1'b0;
      rx_frame_err_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      rx_frame_err_reg <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          if (!din_sync_reg) begin
            rx_state_reg <= RX_START;
            rx_cnt_reg <= bit_div >> 1;
          end
        end
        RX_START: begin
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else begin
            rx_state_reg <= din_sync_reg ? RX_IDLE : RX_BITS;
            rx_cnt_reg <= bit_div - 1'b1;
            rx_idx_reg <= 4'h0;
            rx_bad_reg <= 1'b0;
          end
        end
        default: begin
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else begin
            rx_cnt_reg <= bit_div - 1'b1;
            rx_idx_reg <= rx_idx_reg + 1'b1;
            if (rx_idx_reg < PARITY_INDEX) begin
              rx_byte_reg <= {din_sync_reg, rx_byte_reg[7:1]};
            end else if (rx_idx_reg == PARITY_INDEX && parity_on) begin
              rx_bad_reg <= din_sync_reg != parity_of(rx_byte_reg, parity_mode);
            end else begin
              rx_done_reg <= din_sync_reg && !rx_bad_reg;
              rx_frame_err_reg <= !din_sync_reg || rx_bad_reg;
              rx_state_reg <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_valid_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end else if (rx_done_reg) begin
      rx_valid_reg <= 1'b1;
      rx_data_reg <= rx_byte_reg;
    end else if (rx_rd) begin
      rx_valid_reg <= 1'b0;
    end
  end
endmodule // serial_host_ctrl

// File: dv/uart_link_monitor.sv
// Checker watching the serial link.
`timescale 1ns/1ps
module uart_link_monitor
  import uart_link_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Link and flow control.
  input wire logic host_to_dev,
  input wire logic dev_to_host,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic rts_pin_config,
  input wire logic cts_pin_config,
  input wire logic [CNT_W-1:0] flow_threshold_bytes,
  input wire logic [CNT_W-1:0] rx_level
);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  logic [7:0] rts_cnt_reg;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) rts_cnt_reg <= 8'h00;
    else if (!(rts_pin_config && rts_n)) rts_cnt_reg <= 8'h00;
    else if (rts_cnt_reg != 8'hff) rts_cnt_reg <= rts_cnt_reg + 8'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_dev_bit_hold; $changed(dev_to_host) |=> $stable(dev_to_host) [*8]; endproperty
  a_dev_bit_hold: assert property (p_dev_bit_hold) else $error("device bit too short");
  property p_host_low_max; $fell(host_to_dev) |-> ##[1:90] host_to_dev; endproperty
  a_host_low_max: assert property (p_host_low_max) else $error("host stop bit missing");
  property p_rx_cap; rx_level <= 5'h10; endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("receive level above depth");
  property p_cts_high; cts_pin_config && rx_level > flow_threshold_bytes |=> cts_n; endproperty
  a_cts_high: assert property (p_cts_high) else $error("CTS not deasserted");
  property p_cts_low; rx_level < flow_threshold_bytes |=> !cts_n; endproperty
  a_cts_low: assert property (p_cts_low) else $error("CTS not asserted");
  property p_cts_off; !cts_pin_config |=> !cts_n; endproperty
  a_cts_off: assert property (p_cts_off) else $error("CTS used while disabled");
  property p_rts_hold; rts_cnt_reg > 8'h82 |-> !$fell(dev_to_host); endproperty
  a_rts_hold: assert property (p_rts_hold) else $error("character sent under RTS");
  property p_reset_idle; $fell(reset) |-> dev_to_host && host_to_dev && !cts_n && !rts_n; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("link not idle at reset");
  c_cts_raised: cover property (cts_pin_config && cts_n);
  c_rts_long: cover property (rts_cnt_reg == 8'hc8);
  c_host_frame: cover property ($fell(host_to_dev));
endmodule // uart_link_monitor

// File: dv/uart_host_port_flow_control_tb.sv
// Self-checking bench for the device port and host controller.
`timescale 1ns/1ps
module uart_host_port_flow_control_tb;
  import uart_link_pkg::*;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic clock, reset, stop_bits_setting, cts_pin_config, rts_pin_config, sleep_request;
  logic proc_ready, proc_valid, radio_start, radio_valid, radio_drop, read, write;
  logic waitrequest, irq;
  logic [2:0] baud_rate_setting;
  logic [1:0] parity_setting, sleep_mode_select;
  logic [CNT_W-1:0] flow_threshold_bytes, radio_len, rx_level, tx_level;
  logic [7:0] proc_data, radio_data;
  logic [4:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [7:0] q[$];
  int n_mismatch, comparisons;
  uart_link_if link();
  serial_port_device #(.CLOCK_FREQ_HZ(1152000)) i_serial_port_device (.link(link), .*);
  serial_host_ctrl #(.CLOCK_FREQ_HZ(1152000)) i_serial_host_ctrl (.link(link), .*);
  uart_link_monitor i_uart_link_monitor (.clock, .reset, .host_to_dev(link.host_to_dev),
    .dev_to_host(link.dev_to_host), .cts_n(link.cts_n), .rts_n(link.rts_n), .rts_pin_config,
    .cts_pin_config, .flow_threshold_bytes, .rx_level);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int t;
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (waitrequest !== 1'b0 && t < 5000);
    if (t >= 5000) n_mismatch++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic pop_expect(input logic [7:0] e);
    int t;
    t = 0;
    while (proc_valid !== 1'b1 && t < 400) begin
      @(posedge clock);
      t++;
    end
    check({24'h0, proc_data}, {24'h0, e});
    proc_ready <= 1'b1;
    @(posedge clock);
    proc_ready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic host_get(input logic [7:0] e);
    int t;
    t = 0;
    rd = 32'h0;
    while (rd[2] !== 1'b1 && t < 400) begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      t++;
    end
    bus(1'b0, ADDR_RXDATA, 32'h0);
    check(rd, {24'h0, e});
  endtask
  task automatic radio_packet(input int n, input logic drop_exp);
    logic [7:0] b;
    @(posedge clock);
    radio_start <= 1'b1;
    radio_len <= CNT_W'(n);
    @(posedge clock);
    radio_start <= 1'b0;
    @(posedge clock);
    check({31'h0, radio_drop}, {31'h0, drop_exp});
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      if (!drop_exp) q.push_back(b);
      radio_data <= b;
      radio_valid <= 1'b1;
      @(posedge clock);
    end
    radio_valid <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    @(posedge clock);
    check({31'h0, irq}, {31'h0, e});
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {reset, rts_pin_config, sleep_mode_select} = {1'b1, 1'b1, 2'h1};
    {stop_bits_setting, cts_pin_config, sleep_request, proc_ready} = 4'h0;
    {radio_start, radio_valid, read, write, address, writedata} = '0;
    {radio_len, radio_data, parity_setting} = '0;
    baud_rate_setting = 3'h7;
    flow_threshold_bytes = 5'h4;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(28));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, ADDR_CTRL, 32'h0);
    check(rd, {23'h0, CTRL_RESET});
    bus(1'b0, 5'h18, 32'h0);
    check(rd, UNMAPPED_READ);
    for (int c = 0; c < 2; c++) begin
      cts_pin_config <= c[0];
      bus(1'b1, ADDR_CTRL, 32'h47);
      q.delete();
      for (int i = 0; i < 18; i++) q.push_back(i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($urandom));
      fork
        foreach (q[i]) bus(1'b1, ADDR_TXDATA, {24'h0, q[i]});
        begin
          repeat (2100) @(posedge clock);
          if (c == 0) check({27'h0, rx_level}, 32'h10);
          else check({30'h0, link.cts_n, rx_level < 5'h7}, 32'h3);
          for (int i = 0; i < (c == 0 ? 16 : 18); i++) pop_expect(q[i]);
        end
      join
    end
    bus(1'b1, ADDR_IRQ_STATUS, 32'hf);
    bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h187);
    q.delete();
    radio_packet(16, 1'b0);
    radio_packet(1, 1'b1);
    repeat (300) @(posedge clock);
    check({26'h0, tx_level, link.dev_to_host}, {27'h10, 1'b1});
    irq_is(1'b0);
    bus(1'b1, ADDR_CTRL, 32'h087);
    foreach (q[i]) host_get(q[i]);
    irq_is(1'b1);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    irq_is(1'b1);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
    irq_is(1'b0);
    rts_pin_config <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h187);
    q.delete();
    radio_packet(3, 1'b0);
    foreach (q[i]) host_get(q[i]);
    bus(1'b1, ADDR_CTRL, 32'h037);
    {parity_setting, stop_bits_setting} <= 3'h5;
    sleep_request <= 1'b1;
    repeat (20) @(posedge clock);
    check({30'h0, link.dev_to_host, link.cts_n}, 32'h0);
    sleep_request <= 1'b0;
    repeat (20) @(posedge clock);
    check({31'h0, link.dev_to_host}, 32'h1);
    repeat (90) @(posedge clock);
    bus(1'b0, ADDR_RXDATA, 32'h0);
    q.delete();
    radio_packet(2, 1'b0);
    foreach (q[i]) host_get(q[i]);
    complete_run();
  end
endmodule // uart_host_port_flow_control_tb
